// ==== i2c_pkg.sv ====
// shared constants, register maps and state codes for both link ends
// assumes a 125 MHz pclk and APB register access with byte addresses
package i2c_pkg;
    // slave end register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_OWN   = 8'h08;
    localparam logic [7:0] OFS_DATA  = 8'h0C;
    localparam logic [7:0] OFS_ISTAT = 8'h10;
    localparam logic [7:0] OFS_IMASK = 8'h14;

    // slave_bus_status_control field positions and power-on value
    localparam int         B_DONE   = 7;
    localparam int         B_HIT    = 6;
    localparam int         B_BUSY   = 5;
    localparam int         B_TXSEL  = 4;
    localparam int         B_ACKO   = 3;
    localparam int         B_RDREQ  = 2;
    localparam int         B_WAKE   = 1;
    localparam int         B_ACKI   = 0;
    localparam logic [7:0] STAT_POR = 8'h81;

    // interface_control_zero fields
    localparam int         MODE_MSB = 7;
    localparam int         MODE_LSB = 5;
    localparam int         B_EN     = 1;
    localparam logic [2:0] MODE_I2C = 3'h6;

    // interrupt status and mask bits
    localparam int IRQ_HIT  = 0;
    localparam int IRQ_DONE = 1;

    // bit counters
    localparam logic [3:0] CNT_BYTE = 4'h8;
    localparam logic [3:0] CNT_TXL  = 4'h7;

    // master end register byte offsets and fields
    localparam logic [7:0] M_OFS_CMD   = 8'h00;
    localparam logic [7:0] M_OFS_TX    = 8'h04;
    localparam logic [7:0] M_OFS_RX    = 8'h08;
    localparam logic [7:0] M_OFS_STAT  = 8'h0C;
    localparam logic [7:0] M_OFS_ISTAT = 8'h10;
    localparam logic [7:0] M_OFS_IMASK = 8'h14;
    localparam int         C_START     = 0;
    localparam int         C_XFER      = 1;
    localparam int         C_STOP      = 2;
    localparam int         C_READ      = 3;
    localparam int         C_ACK       = 4;
    localparam int         MS_BUSY     = 0;
    localparam int         MS_ACK      = 1;

    // quarter period of the generated clock, least time, rounded up
    localparam int         QTR_NS    = 40;
    localparam int         PCLK_MHZ  = 125;
    localparam int         QTR_CYC   = (QTR_NS * PCLK_MHZ + 999) / 1000;
    localparam logic [3:0] QTR_LAST  = 4'(QTR_CYC - 1);
    localparam logic [3:0] M_BITLAST = 4'h8;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_ADDR = 7'h02,
        S_AACK = 7'h04,
        S_RX   = 7'h08,
        S_RACK = 7'h10,
        S_TX   = 7'h20,
        S_TACK = 7'h40
    } slave_state_e;

    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_START = 4'h2,
        M_BIT   = 4'h4,
        M_STOP  = 4'h8
    } master_state_e;

    // register address decode
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        return a == ofs;
    endfunction : reg_hit
endpackage : i2c_pkg

// ==== i2c_if.sv ====
// open-drain two-wire link between bus master and slave
// assumes each end drives output and enable only; pull-ups modelled here
`timescale 1ns/1ps
interface i2c_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic scl_s_o;
    logic scl_s_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // wired-and with pull-up
    assign scl = (~scl_m_oe | scl_m_o) & (~scl_s_oe | scl_s_o);
    assign sda = (~sda_m_oe | sda_m_o) & (~sda_s_oe | sda_s_o);

    modport master (input scl, sda,
                    output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe);
    modport slave  (input scl, sda,
                    output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe);
endinterface : i2c_if

// ==== sync2.sv ====
// two-flop synchroniser for a level from outside the pclk domain
// assumes pclk and active-low asynchronous presetn
`timescale 1ns/1ps
module sync2 (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_s;

    sync_s r_q;
    sync_s r_d;

    // second flop alone reads the first
    always_comb begin
        r_d    = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule : sync2

// ==== i2c_slave_status_control.sv ====
// slave end: address match, byte transfer, ack and clock hold, APB regs
// assumes the bus master on i2c_if and APB software on pclk
`timescale 1ns/1ps
module i2c_slave_status_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             wake_req,
    i2c_if.slave             bus
);
    import i2c_pkg::*;

    typedef struct packed {
        slave_state_e st;
        logic [3:0]   cnt;
        logic [7:0]   sh;
        logic [7:0]   data;
        logic [7:0]   ctrl0;
        logic [6:0]   own;
        logic         scl_p;
        logic         sda_p;
        logic         hold;
        logic         sda_oe;
        logic         busy;
        logic         tx_sel;
        logic         ack_out;
        logic         rd_req;
        logic         wake_en;
        logic         ack_in;
        logic         addr_hit;
        logic         byte_done;
        logic         wake;
        logic [1:0]   istat;
        logic [1:0]   imask;
        logic [31:0]  rdata;
    } slave_s;

    slave_s     r_q;
    slave_s     r_d;
    logic       scl_s;
    logic       sda_s;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       en;
    logic       wr;
    logic       rd;
    logic       mapped;
    logic [1:0] ev;
    logic [7:0] stat;

    sync2 u_scl (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (bus.scl),
        .q       (scl_s)
    );

    sync2 u_sda (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (bus.sda),
        .q       (sda_s)
    );

    // line events from synchronised levels
    assign rise  = scl_s & ~r_q.scl_p;
    assign fall  = ~scl_s & r_q.scl_p;
    assign start = scl_s & r_q.scl_p & r_q.sda_p & ~sda_s;
    assign stop  = scl_s & r_q.scl_p & ~r_q.sda_p & sda_s;
    assign en    = (r_q.ctrl0[MODE_MSB:MODE_LSB] == MODE_I2C)
                   && r_q.ctrl0[B_EN];
    assign wr    = psel & penable & pwrite;
    assign rd    = psel & penable & ~pwrite;
    assign mapped = reg_hit(paddr, OFS_CTRL0) | reg_hit(paddr, OFS_STAT)
                  | reg_hit(paddr, OFS_OWN) | reg_hit(paddr, OFS_DATA)
                  | reg_hit(paddr, OFS_ISTAT) | reg_hit(paddr, OFS_IMASK);
    assign stat  = {r_q.byte_done, r_q.addr_hit, r_q.busy, r_q.tx_sel,
                    r_q.ack_out, r_q.rd_req, r_q.wake_en, r_q.ack_in};

    // register access, then bus sequencing; bus updates win
    always_comb begin
        r_d       = r_q;
        ev        = 2'h0;
        r_d.scl_p = scl_s;
        r_d.sda_p = sda_s;
        // read data captured in the setup cycle
        if (psel && !penable) begin
            r_d.rdata = 32'h0;
            if (reg_hit(paddr, OFS_CTRL0)) r_d.rdata[7:0] = r_q.ctrl0;
            if (reg_hit(paddr, OFS_STAT))  r_d.rdata[7:0] = stat;
            if (reg_hit(paddr, OFS_OWN))   r_d.rdata[7:0] = {r_q.own, 1'b0};
            if (reg_hit(paddr, OFS_DATA))  r_d.rdata[7:0] = r_q.data;
            if (reg_hit(paddr, OFS_ISTAT)) r_d.rdata[1:0] = r_q.istat;
            if (reg_hit(paddr, OFS_IMASK)) r_d.rdata[1:0] = r_q.imask;
        end
        if (wr && reg_hit(paddr, OFS_CTRL0)) r_d.ctrl0 = pwdata[7:0];
        if (wr && reg_hit(paddr, OFS_STAT)) begin
            r_d.tx_sel  = pwdata[B_TXSEL];
            r_d.ack_out = pwdata[B_ACKO];
            r_d.rd_req  = pwdata[B_RDREQ];
            r_d.wake_en = pwdata[B_WAKE];
        end
        if (wr && reg_hit(paddr, OFS_OWN)) r_d.own = pwdata[7:1];
        if (wr && reg_hit(paddr, OFS_IMASK)) r_d.imask = pwdata[1:0];
        if (rd && reg_hit(paddr, OFS_ISTAT)) r_d.istat = 2'h0;
        // dummy read in receive mode frees the clock
        if (rd && reg_hit(paddr, OFS_DATA) && r_q.hold
            && r_q.st == S_RX) begin
            r_d.hold      = 1'b0;
            r_d.byte_done = 1'b0;
        end
        // data write in transmit mode loads the byte and frees the clock
        if (wr && reg_hit(paddr, OFS_DATA)) begin
            r_d.data = pwdata[7:0];
            if (r_q.hold && r_q.tx_sel && r_q.st inside {S_TX, S_RX}) begin
                r_d.st        = S_TX;
                r_d.sh        = pwdata[7:0];
                r_d.sda_oe    = ~pwdata[7];
                r_d.hold      = 1'b0;
                r_d.cnt       = 4'h0;
                r_d.byte_done = 1'b0;
            end
        end
        if (start) begin
            r_d.busy     = 1'b1;
            r_d.st       = en ? S_ADDR : S_IDLE;
            r_d.cnt      = 4'h0;
            r_d.addr_hit = 1'b0;
            r_d.sda_oe   = 1'b0;
            r_d.hold     = 1'b0;
        end else if (stop) begin
            r_d.busy   = 1'b0;
            r_d.st     = S_IDLE;
            r_d.sda_oe = 1'b0;
            r_d.hold   = 1'b0;
        end else if (rise) begin
            case (r_q.st)
                S_ADDR, S_RX: begin
                    r_d.sh  = {r_q.sh[6:0], sda_s};
                    r_d.cnt = r_q.cnt + 4'h1;
                end
                S_TACK: r_d.ack_in = sda_s;
                default: ;
            endcase
        end else if (fall) begin
            case (r_q.st)
                S_ADDR: begin
                    if (r_q.cnt == CNT_BYTE) begin
                        if (r_q.sh[7:1] == r_q.own) begin
                            r_d.addr_hit     = 1'b1;
                            ev[IRQ_HIT]      = 1'b1;
                            r_d.rd_req       = r_q.sh[0];
                            r_d.byte_done    = 1'b1;
                            r_d.sda_oe       = 1'b1;
                            r_d.st           = S_AACK;
                            if (r_q.wake_en) r_d.wake = 1'b1;
                        end else begin
                            r_d.st = S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    r_d.sda_oe = 1'b0;
                    r_d.hold   = 1'b1;
                    r_d.cnt    = 4'h0;
                    r_d.st     = r_q.tx_sel ? S_TX : S_RX;
                end
                S_RX: begin
                    if (r_q.cnt == CNT_BYTE) begin
                        r_d.data      = r_q.sh;
                        r_d.byte_done = 1'b1;
                        ev[IRQ_DONE]  = 1'b1;
                        r_d.sda_oe    = ~r_q.ack_out;
                        r_d.st        = S_RACK;
                    end
                end
                S_RACK: begin
                    r_d.sda_oe = 1'b0;
                    r_d.hold   = 1'b1;
                    r_d.cnt    = 4'h0;
                    r_d.st     = S_RX;
                end
                S_TX: begin
                    if (r_q.cnt == CNT_TXL) begin
                        r_d.sda_oe = 1'b0;
                        r_d.st     = S_TACK;
                    end else begin
                        r_d.sda_oe = ~r_q.sh[6];
                        r_d.sh     = {r_q.sh[6:0], 1'b0};
                        r_d.cnt    = r_q.cnt + 4'h1;
                    end
                end
                S_TACK: begin
                    r_d.byte_done = 1'b1;
                    ev[IRQ_DONE]  = 1'b1;
                    if (!r_q.ack_in) begin
                        r_d.hold = 1'b1;
                        r_d.cnt  = 4'h0;
                        r_d.st   = S_TX;
                    end else begin
                        r_d.st = S_IDLE;
                    end
                end
                default: ;
            endcase
        end
        if (!r_d.wake_en) r_d.wake = 1'b0;
        // set wins over the read clear
        r_d.istat = r_d.istat | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q           <= '0;
            r_q.st        <= S_IDLE;
            r_q.scl_p     <= 1'b1;
            r_q.sda_p     <= 1'b1;
            r_q.byte_done <= STAT_POR[B_DONE];
            r_q.ack_in    <= STAT_POR[B_ACKI];
        end else begin
            r_q <= r_d;
        end
    end

    // outputs
    assign prdata       = r_q.rdata;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & ~mapped;
    assign irq          = |(r_q.istat & r_q.imask);
    assign wake_req     = r_q.wake;
    assign bus.scl_s_o  = 1'b0;
    assign bus.scl_s_oe = r_q.hold;
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = r_q.sda_oe;
endmodule : i2c_slave_status_control

// ==== i2c_bus_master.sv ====
// master end: start, nine-bit byte transfer and stop on command over APB
// assumes the slave on i2c_if may hold the clock low between bits
`timescale 1ns/1ps
module i2c_bus_master (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    i2c_if.master            bus
);
    import i2c_pkg::*;

    typedef struct packed {
        master_state_e st;
        logic [1:0]    ph;
        logic [3:0]    qcnt;
        logic [3:0]    bits;
        logic [8:0]    out;
        logic [8:0]    inb;
        logic [7:0]    txd;
        logic [7:0]    rxd;
        logic          ack;
        logic          do_start;
        logic          do_xfer;
        logic          do_stop;
        logic          owned;
        logic          istat;
        logic          imask;
        logic [31:0]   rdata;
    } master_s;

    master_s r_q;
    master_s r_d;
    logic    scl_s;
    logic    sda_s;
    logic    waitg;
    logic    adv;
    logic    mapped;
    logic    wr;

    sync2 u_scl (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (bus.scl),
        .q       (scl_s)
    );

    sync2 u_sda (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (bus.sda),
        .q       (sda_s)
    );

    // next step after a finished one: data first, then stop
    function automatic master_state_e pick(input logic x, input logic p);
        return x ? M_BIT : (p ? M_STOP : M_IDLE);
    endfunction : pick

    // quarter timer; the clock-release phase of a bit or a stop waits for it to rise
    assign waitg  = (r_q.st == M_BIT || r_q.st == M_STOP) && r_q.ph == 2'h1;
    assign adv    = (r_q.qcnt == QTR_LAST) && (!waitg || scl_s);
    assign wr     = psel & penable & pwrite;
    assign mapped = reg_hit(paddr, M_OFS_CMD) | reg_hit(paddr, M_OFS_TX)
                  | reg_hit(paddr, M_OFS_RX) | reg_hit(paddr, M_OFS_STAT)
                  | reg_hit(paddr, M_OFS_ISTAT) | reg_hit(paddr, M_OFS_IMASK);

    always_comb begin
        r_d = r_q;
        if (psel && !penable) begin
            r_d.rdata = 32'h0;
            if (reg_hit(paddr, M_OFS_TX)) r_d.rdata[7:0] = r_q.txd;
            if (reg_hit(paddr, M_OFS_RX)) r_d.rdata[7:0] = r_q.rxd;
            if (reg_hit(paddr, M_OFS_STAT)) begin
                r_d.rdata[MS_BUSY] = r_q.st != M_IDLE;
                r_d.rdata[MS_ACK]  = r_q.ack;
            end
            if (reg_hit(paddr, M_OFS_ISTAT)) r_d.rdata[0] = r_q.istat;
            if (reg_hit(paddr, M_OFS_IMASK)) r_d.rdata[0] = r_q.imask;
        end
        if (wr && reg_hit(paddr, M_OFS_TX)) r_d.txd = pwdata[7:0];
        if (wr && reg_hit(paddr, M_OFS_IMASK)) r_d.imask = pwdata[0];
        if (!penable && psel && !pwrite && reg_hit(paddr, M_OFS_ISTAT)) begin
        end
        if (psel && penable && !pwrite && reg_hit(paddr, M_OFS_ISTAT)) begin
            r_d.istat = 1'b0;
        end
        // commands are taken only while idle
        if (wr && reg_hit(paddr, M_OFS_CMD) && r_q.st == M_IDLE) begin
            r_d.do_start = pwdata[C_START];
            r_d.do_xfer  = pwdata[C_XFER];
            r_d.do_stop  = pwdata[C_STOP];
            r_d.out      = pwdata[C_READ] ? {8'hFF, pwdata[C_ACK]}
                                          : {r_q.txd, 1'b1};
            r_d.bits     = 4'h0;
        end
        r_d.qcnt = (r_q.st == M_IDLE || adv || (waitg && !scl_s))
                   ? 4'h0 : r_q.qcnt + 4'h1;
        case (r_q.st)
            M_IDLE: begin
                r_d.ph = 2'h0;
                if (r_q.do_start) begin
                    r_d.st = M_START;
                end else begin
                    r_d.st = pick(r_q.do_xfer, r_q.do_stop);
                end
            end
            M_START: begin
                if (adv) begin
                    r_d.ph = r_q.ph + 2'h1;
                    if (r_q.ph == 2'h1) begin
                        r_d.ph       = 2'h0;
                        r_d.do_start = 1'b0;
                        r_d.owned    = 1'b1;
                        r_d.st       = pick(r_q.do_xfer, r_q.do_stop);
                    end
                end
            end
            M_BIT: begin
                if (adv) begin
                    r_d.ph = r_q.ph + 2'h1;
                    if (r_q.ph == 2'h2) r_d.inb = {r_q.inb[7:0], sda_s};
                    if (r_q.ph == 2'h3) begin
                        r_d.out  = {r_q.out[7:0], 1'b1};
                        r_d.bits = r_q.bits + 4'h1;
                        if (r_q.bits == M_BITLAST) begin
                            r_d.do_xfer = 1'b0;
                            r_d.rxd     = r_q.inb[8:1];
                            r_d.ack     = r_q.inb[0];
                            r_d.st      = pick(1'b0, r_q.do_stop);
                        end
                    end
                end
            end
            M_STOP: begin
                if (adv) begin
                    r_d.ph = r_q.ph + 2'h1;
                    if (r_q.ph == 2'h2) begin
                        r_d.ph      = 2'h0;
                        r_d.do_stop = 1'b0;
                        r_d.owned   = 1'b0;
                        r_d.st      = M_IDLE;
                    end
                end
            end
            default: r_d.st = M_IDLE;
        endcase
        // finished sequence raises the done event; set wins over clear
        if (r_q.st != M_IDLE && r_d.st == M_IDLE) r_d.istat = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q    <= '0;
            r_q.st <= M_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    // pin enables decoded from registered state and phase; between commands
    // an owned bus keeps scl low so a released slave hold clocks no bit
    assign bus.scl_m_o  = 1'b0;
    assign bus.sda_m_o  = 1'b0;
    assign bus.scl_m_oe = (r_q.st == M_START && r_q.ph == 2'h1)
                        | (r_q.st == M_BIT && (r_q.ph == 2'h0
                                               || r_q.ph == 2'h3))
                        | (r_q.st == M_STOP && r_q.ph == 2'h0)
                        | (r_q.st == M_IDLE && r_q.owned);
    assign bus.sda_m_oe = (r_q.st == M_START)
                        | (r_q.st == M_BIT && !r_q.out[8])
                        | (r_q.st == M_STOP && r_q.ph != 2'h2);
    assign prdata  = r_q.rdata;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign irq     = r_q.istat & r_q.imask;
endmodule : i2c_bus_master

// ==== i2c_link_props.sv ====
// checker: framing, slave drive and clock hold on the shared wires
// assumes plain copies of the interface lines and the pclk domain
`timescale 1ns/1ps
module i2c_link_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_s_oe,
    input wire logic sda_s_oe
);
    logic       scl_p_q, sda_p_q, busy_q, addr_q, rw_q;
    logic [3:0] cnt_q;
    wire start = scl_p_q && scl && sda_p_q && !sda;
    wire stop  = scl_p_q && scl && !sda_p_q && sda;
    wire rise  = !scl_p_q && scl;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bit count in the byte, address phase and direction bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {scl_p_q, sda_p_q, busy_q, addr_q, rw_q} <= 5'h18;
            cnt_q <= 4'h0;
        end else begin
            {scl_p_q, sda_p_q} <= {scl, sda};
            if (start) begin
                {busy_q, addr_q} <= 2'h3;
                cnt_q <= 4'h0;
            end else if (rise) begin
                cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
                if (addr_q && cnt_q == 4'h7) rw_q <= sda;
                if (cnt_q == 4'h8) addr_q <= 1'b0;
            end
            if (stop) busy_q <= 1'b0;
        end
    end
    property p_sda_low; $changed(sda_s_oe) |-> !scl; endproperty
    property p_idle; !busy_q |-> !sda_s_oe && !scl_s_oe; endproperty
    property p_aack; addr_q && rise && sda_s_oe |-> cnt_q == 4'h8; endproperty
    property p_hold; $rose(scl_s_oe) |-> cnt_q == 4'h9; endproperty
    property p_start; start |-> !busy_q; endproperty
    // the stop's own clock rise opens a new count after the ninth bit
    property p_stop; stop |-> cnt_q == 4'h1; endproperty
    property p_wr; !addr_q && !rw_q && rise && cnt_q != 4'h8 |-> !sda_s_oe;
    endproperty
    property p_rd; !addr_q && rw_q && rise && cnt_q == 4'h8 |-> !sda_s_oe;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda moved");
    a_idle: assert property (p_idle) else $error("drive idle");
    a_aack: assert property (p_aack) else $error("addr ack bit");
    a_hold: assert property (p_hold) else $error("hold bit");
    a_start: assert property (p_start) else $error("start busy");
    a_stop: assert property (p_stop) else $error("stop bit");
    a_wr: assert property (p_wr) else $error("rx drive");
    a_rd: assert property (p_rd) else $error("tx ack drive");
    c_start: cover property (start);
    c_hold: cover property ($rose(scl_s_oe));
    c_read: cover property (rise && !addr_q && rw_q);
endmodule : i2c_link_props

// ==== i2c_slave_status_control_tb.sv ====
// bench: both link ends joined, each driven over its register bus
// assumes the package, interface and both ends compiled first
`timescale 1ns/1ps
module i2c_slave_status_control_tb;
    import i2c_pkg::*;
    localparam logic [6:0] ADDR = 7'h5A;
    localparam int S = 0, M = 1;
    logic             pclk = 0, presetn = 0, err;
    logic [1:0]       psel = 0, penable = 0, pwrite = 0;
    logic [1:0][7:0]  paddr = '0;
    logic [1:0][31:0] pwdata = '0;
    wire  [1:0][31:0] prdata;
    wire  [1:0]       pready, pslverr, irq;
    wire              wake_req;
    int               n_fail = 0, check_count = 0, cyc = 0;
    i2c_if u_i2c_if ();
    i2c_slave_status_control u_i2c_slave_status_control (.pclk, .presetn,
        .psel(psel[S]), .penable(penable[S]), .pwrite(pwrite[S]),
        .paddr(paddr[S]), .pwdata(pwdata[S]), .prdata(prdata[S]),
        .pready(pready[S]), .pslverr(pslverr[S]), .irq(irq[S]),
        .wake_req, .bus(u_i2c_if));
    i2c_bus_master u_i2c_bus_master (.pclk, .presetn,
        .psel(psel[M]), .penable(penable[M]), .pwrite(pwrite[M]),
        .paddr(paddr[M]), .pwdata(pwdata[M]), .prdata(prdata[M]),
        .pready(pready[M]), .pslverr(pslverr[M]), .irq(irq[M]),
        .bus(u_i2c_if));
    i2c_link_props u_i2c_link_props (.pclk, .presetn, .scl(u_i2c_if.scl),
        .sda(u_i2c_if.sda), .scl_s_oe(u_i2c_if.scl_s_oe),
        .sda_s_oe(u_i2c_if.sda_s_oe));
    initial forever #4 pclk = ~pclk;
    task automatic report_and_stop;
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // one apb transfer: setup, access until pready, release
    task automatic xfer(int s, logic w, logic [7:0] a, logic [31:0] d,
                        output logic [31:0] r);
        {psel[s], pwrite[s], paddr[s], pwdata[s]} <= {1'b1, w, a, d};
        @(posedge pclk) penable[s] <= 1'b1;
        do @(posedge pclk); while (pready[s] !== 1'b1);
        {r, err} = {prdata[s], pslverr[s]};
        {psel[s], penable[s]} <= 2'b00;
        @(posedge pclk);
    endtask : xfer
    task automatic wr(int s, logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        xfer(s, 1'b1, a, d, r);
    endtask : wr
    task automatic rd(int s, logic [7:0] a, logic [31:0] e,
                      logic [31:0] m = 32'hFFFFFFFF);
        logic [31:0] r;
        xfer(s, 1'b0, a, 32'h0, r);
        chk($sformatf("rd%0d_%h", s, a), e, r & m);
    endtask : rd
    task automatic wait_irq(int s);
        for (int n = 0; n < 4000 && irq[s] !== 1'b1; n++) @(posedge pclk);
        chk($sformatf("irq%0d", s), 1, irq[s]);
    endtask : wait_irq
    // master command, wait for its done, clear it
    task automatic mx(logic [31:0] c);
        wr(M, M_OFS_CMD, c);
        wait_irq(M);
        rd(M, M_OFS_ISTAT, 1);
    endtask : mx
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(S, OFS_STAT, STAT_POR);
        rd(S, 8'h18, 0);
        chk("slverr", 1, err);
        wr(S, OFS_CTRL0, 32'hC2);
        wr(S, OFS_OWN, {ADDR, 1'b0});
        wr(S, OFS_IMASK, 3);
        wr(M, M_OFS_IMASK, 1);
        wr(S, OFS_STAT, 2);
        // master writes two bytes, acked then refused
        wr(M, M_OFS_TX, {ADDR, 1'b0});
        mx(3);
        rd(M, M_OFS_STAT, 0, 2);
        wait_irq(S);
        rd(S, OFS_STAT, 32'hE2, 32'hFE);
        chk("wake", 1, wake_req);
        wr(S, OFS_STAT, 0);
        chk("wake", 0, wake_req);
        rd(S, OFS_ISTAT, 1);
        chk("irq_clr", 0, irq[S]);
        rd(S, OFS_DATA, 0);
        for (int i = 0; i < 2; i++) begin
            wr(S, OFS_STAT, i << B_ACKO);
            wr(M, M_OFS_TX, 8'hA5 ^ i);
            mx(2);
            rd(M, M_OFS_STAT, i << MS_ACK, 2);
            wait_irq(S);
            rd(S, OFS_ISTAT, 2);
            rd(S, OFS_DATA, 8'hA5 ^ i);
        end
        mx(4);
        rd(S, OFS_STAT, 0, 32'h20);
        // master reads two bytes, acks the first only
        wr(M, M_OFS_TX, {ADDR, 1'b1});
        mx(3);
        wait_irq(S);
        rd(S, OFS_STAT, 32'h64, 32'h64);
        rd(S, OFS_ISTAT, 1);
        wr(S, OFS_STAT, 32'h10);
        for (int i = 0; i < 2; i++) begin
            if (i == 1) wr(S, OFS_IMASK, 1);
            wr(S, OFS_DATA, 8'h3C ^ i);
            mx(32'hA | (i << 4));
            rd(M, M_OFS_RX, 8'h3C ^ i);
            rd(S, OFS_STAT, i, 1);
            chk("irq_mask", i == 0, irq[S]);
            rd(S, OFS_ISTAT, 2);
        end
        wr(S, OFS_IMASK, 3);
        mx(4);
        rd(S, OFS_STAT, 0, 32'h20);
        // foreign address: no ack, no event
        wr(M, M_OFS_TX, {ADDR ^ 7'h01, 1'b0});
        mx(7);
        rd(M, M_OFS_STAT, 2, 2);
        rd(S, OFS_ISTAT, 0);
        report_and_stop();
    end
endmodule : i2c_slave_status_control_tb
